/* pcs_pkg.sv */
// package for the socket signalling block: mode codes, carriers, constants
// assumes one 50 MHz clock and a plain register port in the owning module
package pcs_pkg;
  typedef enum logic [1:0] {
    PCS_MODE_NONE = 2'h0,
    PCS_MODE_MEM = 2'h1,
    PCS_MODE_IO = 2'h2,
    PCS_MODE_CB = 2'h3
  } pcs_mode_e;

  // register indices (word addresses)
  localparam logic [3:0] PCS_REG_CTRL = 4'h0;
  localparam logic [3:0] PCS_REG_LEGACY = 4'h1;
  localparam logic [3:0] PCS_REG_STATUS = 4'h2;
  localparam logic [3:0] PCS_REG_CYCLE = 4'h3;
  localparam logic [3:0] PCS_REG_INTGEN = 4'h4;

  // control register fields
  localparam int PCS_CTRL_PWR = 0;
  localparam int PCS_CTRL_IFEN = 1;
  localparam int PCS_CTRL_IOMODE = 2;
  localparam int PCS_CTRL_BUS8 = 3;
  localparam int PCS_CTRL_LEDSEL = 4;
  localparam int PCS_CTRL_RST = 5;
  localparam int PCS_CTRL_PMEEN = 6;
  // legacy register 3Bh, bits 3:2 enable clock run
  localparam int PCS_LEG_CLKRUN_LO = 2;
  localparam int PCS_LEG_CLKRUN_HI = 3;
  // interrupt and general control register 03h, bit 7 ring indicate select
  localparam int PCS_IGC_RING = 7;

  // cycle register: bit 0 write, bit 1 io, bit 2 word, bit 3 addr0, bit 4 go
  localparam int PCS_CYC_WR = 0;
  localparam int PCS_CYC_IO = 1;
  localparam int PCS_CYC_WORD = 2;
  localparam int PCS_CYC_A0 = 3;
  localparam int PCS_CYC_GO = 4;

  localparam logic [7:0] PCS_RESET_BYTE = 8'h00;
  localparam int PCS_STROBE_NS = 100;
  localparam int PCS_CLK_MHZ = 50;
  localparam int PCS_STROBE_CYC = (PCS_STROBE_NS * PCS_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] PCS_STROBE_CNT = 4'(PCS_STROBE_CYC);

  typedef struct packed {
    logic io_read_strobe_n_n;
    logic iowr_n;
    logic oe_n;
    logic we_n;
    logic ce1_n;
    logic ce2_n;
    logic a0;
  } pcs_strobe_s;

  // card side inputs, all asynchronous
  typedef struct packed {
    logic wp_io16;
    logic input_ack_n;
    logic rdy_irq;
    logic wait_n;
    logic [1:0] cd_n;
    logic battery_warn_in;
    logic battery_dead_in;
    logic [1:0] vs;
    logic clkrun_n;
  } pcs_cardin_s;
endpackage

/* pcs_socket.sv */
// socket signalling for one pc card / cardbus slot, controller side
// assumes card pins are asynchronous; register port is on SYS_CLK
//
// Local design decisions: the address map and the plain strobed port.
`timescale 1ns/1ps

// Function
// R1 - io read strobe low on io read; cardbus address/data bit 13
// R2 - io write strobe low on io write; cardbus address/data bit 15
// R3 - shared input is write protect in memory mode, 16-bit size in io
// R4 - cardbus clock run handshake only when legacy bits 3:2 enable it
// R5 - input acknowledge ignored; cardbus bus request input
// R6 - status input is ready/busy in memory, interrupt request in io
// R7 - cardbus interrupt active low, pending while line held low
// R8 - wait extends current cycle; cardbus system error
// R9 - card presence from two pulled-up detect inputs; combine with sense in cardbus
// R10 - odd byte enable for odd bytes, even enable for even, per width
// R11 - 8-bit card: only even enable, address bit 0 selects byte
// R12 - card reset released from high impedance only when seated, powered, enabled
// R13 - battery warning in memory (code drops it there, audio held low); audio or led in io; audio in cardbus
// R14 - battery dead in memory; status change or ring via bit 7 in io
// R15 - cardbus status change can raise power management event
// R16 - voltage sense sampled with detect before socket power
// R17 - cardbus: even enable pin is command/byte enable 0
// R18 - output enable low on memory read; cardbus address/data bit 11
// R19 - write enable low on memory write; cardbus grant output
// R20 - one socket mode state selects every shared pin meaning (code: the cycle io bit picks the size reading in the cycle engine)
module pcs_socket
  import pcs_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // register port
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // card side inputs
  input wire pcs_cardin_s CARD_IN,
  input wire logic CARD_CLK,
  // cardbus multiplexed bits driven from the bridge
  input wire logic CB_AD11,
  input wire logic CB_AD13,
  input wire logic CB_AD15,
  input wire logic CB_CBE0_N,
  input wire logic CB_GNT_N,
  // socket strobes
  output pcs_strobe_s SOCKET_OUT,
  // card reset, tristate
  output logic CARD_RESET_O,
  output logic CARD_RESET_OE,
  // status to the bridge
  output pcs_mode_e SOCKET_MODE,
  output logic CARD_IRQ,
  output logic CARD_SERR,
  output logic CARD_BUS_REQ,
  output logic CARD_AUDIO,
  output logic PME_EVENT,
  output logic CLKRUN_ACTIVE,
  output logic CYCLE_BUSY
);
  // ----------------------------------------
  // input synchronisers
  // ----------------------------------------
  pcs_cardin_s in_s1_q, in_q;
  logic clk_s1_q, clk_q, clk_prev_q;
  always_ff @(posedge SYS_CLK) begin
    in_s1_q <= CARD_IN;
    in_q <= in_s1_q;
    clk_s1_q <= CARD_CLK;
    clk_q <= clk_s1_q;
    clk_prev_q <= clk_q;
  end
  logic card_clk_rise;
  assign card_clk_rise = clk_q & ~clk_prev_q;

  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [7:0] ctrl_q, legacy_q, intgen_q, cyc_q;
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      ctrl_q <= PCS_RESET_BYTE;
      legacy_q <= PCS_RESET_BYTE;
      intgen_q <= PCS_RESET_BYTE;
    end else if (REG_WR) begin
      case (REG_ADDR)
        PCS_REG_CTRL: ctrl_q <= REG_WDATA;
        PCS_REG_LEGACY: legacy_q <= REG_WDATA;
        PCS_REG_INTGEN: intgen_q <= REG_WDATA;
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // mode decode
  // ----------------------------------------
  // the pc card test gates the cycle engine, the cardbus test the pin mux
  function automatic logic mode_is_cb(input pcs_mode_e m);
    return m == PCS_MODE_CB;
  endfunction
  function automatic logic mode_is_pccard(input pcs_mode_e m);
    return m == PCS_MODE_MEM || m == PCS_MODE_IO;
  endfunction

  // ----------------------------------------
  // presence, type and mode
  // ----------------------------------------
  logic seated;
  logic [1:0] vs_q;
  logic cb_card_q;
  logic cb_card;
  pcs_mode_e mode_q;
  assign seated = (in_q.cd_n == 2'h0); // R9
  // live sense while unpowered, latched type once powered: no memory-mode blip on insertion
  assign cb_card = ctrl_q[PCS_CTRL_PWR] ? cb_card_q : (seated & (in_q.vs != 2'h3)); // R9 R16
  // sense latched only while unpowered, so a live card cannot change type
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      vs_q <= 2'h3;
      cb_card_q <= 1'b0;
    end else if (!ctrl_q[PCS_CTRL_PWR]) begin
      vs_q <= in_q.vs; // R16
      cb_card_q <= seated & (in_q.vs != 2'h3); // R9 R16
    end
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      mode_q <= PCS_MODE_NONE;
    end else if (!seated) begin
      mode_q <= PCS_MODE_NONE; // R20
    end else if (cb_card) begin
      mode_q <= PCS_MODE_CB;
    end else if (ctrl_q[PCS_CTRL_IOMODE]) begin
      mode_q <= PCS_MODE_IO;
    end else begin
      mode_q <= PCS_MODE_MEM;
    end
  end

  // ----------------------------------------
  // 16-bit cycle engine
  // ----------------------------------------
  typedef enum logic [1:0] {
    PCS_CYC_IDLE = 2'h0,
    PCS_CYC_STROBE = 2'h1,
    PCS_CYC_WAIT = 2'h2
  } pcs_cyc_e;
  pcs_cyc_e cst_q;
  logic [3:0] cnt_q;
  logic start;
  assign start = REG_WR && REG_ADDR == PCS_REG_CYCLE && REG_WDATA[PCS_CYC_GO]
    && cst_q == PCS_CYC_IDLE && mode_is_pccard(mode_q);
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      cst_q <= PCS_CYC_IDLE;
      cnt_q <= 4'h0;
      cyc_q <= PCS_RESET_BYTE;
    end else begin
      case (cst_q)
        PCS_CYC_IDLE: begin
          if (start) begin
            cyc_q <= REG_WDATA;
            cnt_q <= PCS_STROBE_CNT;
            cst_q <= PCS_CYC_STROBE;
          end
        end
        PCS_CYC_STROBE: begin
          if (cnt_q > 4'h1) begin
            cnt_q <= cnt_q - 4'h1;
          end else begin
            cst_q <= PCS_CYC_WAIT;
          end
        end
        PCS_CYC_WAIT: begin
          if (in_q.wait_n || mode_q == PCS_MODE_NONE) begin // R8
            cst_q <= PCS_CYC_IDLE;
          end
        end
        default: cst_q <= PCS_CYC_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // pin meanings
  // ----------------------------------------
  logic active, io16, bus8;
  pcs_strobe_s st_d, st_q;
  assign active = cst_q != PCS_CYC_IDLE;
  assign bus8 = ctrl_q[PCS_CTRL_BUS8];
  assign io16 = cyc_q[PCS_CYC_IO] ? ~in_q.wp_io16 : 1'b1; // R3
  always_comb begin
    st_d = '1;
    st_d.a0 = 1'b0;
    if (mode_is_cb(mode_q)) begin
      st_d.io_read_strobe_n_n = CB_AD13; // R1
      st_d.iowr_n = CB_AD15; // R2
      st_d.oe_n = CB_AD11; // R18
      st_d.we_n = CB_GNT_N; // R19
      st_d.ce1_n = CB_CBE0_N; // R17
      st_d.ce2_n = 1'b1;
    end else if (active) begin
      st_d.a0 = cyc_q[PCS_CYC_A0];
      st_d.io_read_strobe_n_n = ~(cyc_q[PCS_CYC_IO] & ~cyc_q[PCS_CYC_WR]); // R1
      st_d.iowr_n = ~(cyc_q[PCS_CYC_IO] & cyc_q[PCS_CYC_WR]); // R2
      st_d.oe_n = ~(~cyc_q[PCS_CYC_IO] & ~cyc_q[PCS_CYC_WR]); // R18
      st_d.we_n = ~(~cyc_q[PCS_CYC_IO] & cyc_q[PCS_CYC_WR]); // R19
      if (bus8 || !io16) begin
        st_d.ce1_n = 1'b0; // R11
      end else if (cyc_q[PCS_CYC_WORD]) begin
        st_d.ce1_n = 1'b0; // R10
        st_d.ce2_n = 1'b0;
      end else begin
        st_d.ce1_n = cyc_q[PCS_CYC_A0]; // R10
        st_d.ce2_n = ~cyc_q[PCS_CYC_A0];
      end
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  logic clkrun_en;
  assign clkrun_en = legacy_q[PCS_LEG_CLKRUN_HI:PCS_LEG_CLKRUN_LO] != 2'h0;
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      st_q <= '{io_read_strobe_n_n: 1'b1, iowr_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, ce1_n: 1'b1, ce2_n: 1'b1, a0: 1'b0};
      CARD_RESET_O <= 1'b0;
      CARD_RESET_OE <= 1'b0;
      CARD_IRQ <= 1'b0;
      CARD_SERR <= 1'b0;
      CARD_BUS_REQ <= 1'b0;
      CARD_AUDIO <= 1'b0;
      PME_EVENT <= 1'b0;
      CLKRUN_ACTIVE <= 1'b0;
      CYCLE_BUSY <= 1'b0;
    end else begin
      st_q <= st_d;
      CYCLE_BUSY <= active;
      // cardbus reset is active low on the same pin
      CARD_RESET_O <= (mode_q == PCS_MODE_CB) ? ~ctrl_q[PCS_CTRL_RST] : ctrl_q[PCS_CTRL_RST];
      CARD_RESET_OE <= seated & ctrl_q[PCS_CTRL_PWR] & ctrl_q[PCS_CTRL_IFEN]; // R12
      CARD_SERR <= (mode_q == PCS_MODE_CB) & ~in_q.wait_n; // R8
      CARD_BUS_REQ <= (mode_q == PCS_MODE_CB) & ~in_q.input_ack_n; // R5
      CLKRUN_ACTIVE <= (mode_q == PCS_MODE_CB) & clkrun_en & ~in_q.clkrun_n // R4
        & (card_clk_rise | CLKRUN_ACTIVE);
      PME_EVENT <= (mode_q == PCS_MODE_CB) & ctrl_q[PCS_CTRL_PMEEN] & in_q.battery_dead_in; // R15
      case (mode_q)
        PCS_MODE_MEM: begin
          CARD_IRQ <= 1'b0; // R6
          CARD_AUDIO <= 1'b0; // R13
        end
        PCS_MODE_IO: begin
          CARD_IRQ <= ~in_q.rdy_irq; // R6
          CARD_AUDIO <= ctrl_q[PCS_CTRL_LEDSEL] ? 1'b0 : ~in_q.battery_warn_in; // R13
        end
        PCS_MODE_CB: begin
          CARD_IRQ <= ~in_q.rdy_irq; // R7
          CARD_AUDIO <= in_q.battery_warn_in; // R13
        end
        default: begin
          CARD_IRQ <= 1'b0;
          CARD_AUDIO <= 1'b0;
        end
      endcase
    end
  end
  assign SOCKET_OUT = st_q;
  assign SOCKET_MODE = mode_q;

  // ----------------------------------------
  // read port
  // ----------------------------------------
  logic [7:0] status;
  always_comb begin
    status = 8'h00;
    status[0] = seated;
    status[2:1] = vs_q;
    status[3] = (mode_q == PCS_MODE_MEM) ? in_q.wp_io16 : ~in_q.wp_io16; // R3
    status[4] = (mode_q == PCS_MODE_MEM) & in_q.rdy_irq; // R6
    status[5] = (mode_q == PCS_MODE_MEM) ? in_q.battery_dead_in : 1'b0; // R14
    status[6] = (mode_q == PCS_MODE_IO) & ~intgen_q[PCS_IGC_RING] & ~in_q.battery_dead_in; // R14
    status[7] = (mode_q == PCS_MODE_IO) & intgen_q[PCS_IGC_RING] & ~in_q.battery_dead_in; // R14
  end
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      case (REG_ADDR)
        PCS_REG_CTRL: REG_RDATA <= ctrl_q;
        PCS_REG_LEGACY: REG_RDATA <= legacy_q;
        PCS_REG_STATUS: REG_RDATA <= status;
        PCS_REG_CYCLE: REG_RDATA <= {6'h00, mode_q};
        PCS_REG_INTGEN: REG_RDATA <= intgen_q;
        default: REG_RDATA <= 8'h00;
      endcase
    end else begin
      REG_RDATA <= 8'h00;
    end
  end
endmodule

/* pcs_card_model.sv */
// card model: card pins, wait on each strobe, clock only while seated
// assumes socket enables are watched on the system clock
`timescale 1ns/1ps
module pcs_card_model
  import pcs_pkg::*;
(
  input wire logic clk,
  input wire logic seated,
  input wire logic cb_card,
  input wire logic irq_n,
  input wire logic io16_n,
  input wire logic req_n,
  input wire logic [3:0] wait_len,
  input wire pcs_strobe_s strobes,
  output pcs_cardin_s card_in,
  output logic card_clk
);
  logic [3:0] wcnt_q = 4'h0;
  logic idle_q = 1'b1;
  // odd start offset keeps the link clock out of phase with the system clock
  initial begin
    card_clk = 1'b0;
    #3;
    forever begin
      #80;
      card_clk = seated & ~card_clk;
    end
  end
  // wait held low for wait_len cycles after each enable falls
  always @(posedge clk) begin
    idle_q <= strobes.ce1_n & strobes.ce2_n;
    wcnt_q <= (idle_q && !(strobes.ce1_n & strobes.ce2_n)) ? wait_len : wcnt_q - 4'(wcnt_q != 4'h0);
  end
  // empty socket: every pin floats to its pull-up; clock run never requested
  assign card_in = seated ? {io16_n, req_n, irq_n, wcnt_q == 4'h0, 2'h0, 2'h3, cb_card ? 2'h1 : 2'h3, 1'b1}
    : 11'h7FF;
endmodule

/* pcs_socket_props.sv */
// concurrent checks on the socket block ports
// assumes one clock domain with synchronous active-low reset
`timescale 1ns/1ps
module pcs_socket_props
  import pcs_pkg::*;
(
  // clock and reset
  input wire logic SYS_CLK,
  input wire logic RST_N,
  // observed ports
  input wire logic [3:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire pcs_cardin_s CARD_IN,
  input wire pcs_strobe_s SOCKET_OUT,
  input wire logic CARD_RESET_OE,
  input wire pcs_mode_e SOCKET_MODE,
  input wire logic CARD_IRQ,
  input wire logic CYCLE_BUSY
);
  default clocking clk_def @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);
  logic bus8_q;
  always_ff @(posedge SYS_CLK) begin
    if (!RST_N) begin
      bus8_q <= 1'b0;
    end else if (REG_WR && REG_ADDR == PCS_REG_CTRL) begin
      bus8_q <= REG_WDATA[PCS_CTRL_BUS8];
    end
  end
  sequence go_s;
    REG_WR && REG_ADDR == PCS_REG_CYCLE && REG_WDATA[PCS_CYC_GO] && !CYCLE_BUSY &&
      (SOCKET_MODE == PCS_MODE_MEM || SOCKET_MODE == PCS_MODE_IO);
  endsequence
  sequence start_s;
    ##[1:3] CYCLE_BUSY && !(SOCKET_OUT.ce1_n && SOCKET_OUT.ce2_n);
  endsequence
  AST_GO: assert property (go_s |-> start_s) else $error("cycle did not start");
  AST_IO_READ_STROBE_N: assert property (!SOCKET_OUT.io_read_strobe_n_n && SOCKET_MODE != PCS_MODE_CB |-> SOCKET_MODE == PCS_MODE_IO)
    else $error("io read strobe outside io mode");
  AST_IOWR: assert property (!SOCKET_OUT.iowr_n && SOCKET_MODE != PCS_MODE_CB |-> SOCKET_MODE == PCS_MODE_IO)
    else $error("io write strobe outside io mode");
  AST_BUS8: assert property (bus8_q && SOCKET_MODE != PCS_MODE_CB |-> SOCKET_OUT.ce2_n)
    else $error("odd enable used on 8-bit socket");
  AST_WAIT: assert property (CYCLE_BUSY && !CARD_IN.wait_n && !$past(CARD_IN.wait_n) && !$past(CARD_IN.wait_n, 2)
    |=> CYCLE_BUSY) else $error("cycle ended while wait held");
  AST_NONE: assert property ((CARD_IN.cd_n == 2'h3) [*4] |=> SOCKET_MODE == PCS_MODE_NONE)
    else $error("mode set with no card");
  AST_RST: assert property ((CARD_IN.cd_n != 2'h0) [*4] |=> !CARD_RESET_OE)
    else $error("card reset driven without seated card");
  AST_IRQ: assert property ((!CARD_IN.rdy_irq) [*4] ##0 SOCKET_MODE == PCS_MODE_CB |=> CARD_IRQ)
    else $error("held card interrupt not pending");
endmodule

bind pcs_socket pcs_socket_props pcs_socket_props_inst (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .REG_ADDR(REG_ADDR),
  .REG_WDATA(REG_WDATA), .REG_WR(REG_WR), .CARD_IN(CARD_IN), .SOCKET_OUT(SOCKET_OUT), .CARD_RESET_OE(CARD_RESET_OE),
  .SOCKET_MODE(SOCKET_MODE), .CARD_IRQ(CARD_IRQ), .CYCLE_BUSY(CYCLE_BUSY));

/* pcs_socket_bench.sv */
// bench for pcs_socket: card model, register tasks, reference checks
// assumes the package, card model and bound checker are compiled first
`timescale 1ns/1ps
module pcs_socket_bench
  import pcs_pkg::*;
;
  logic clk, rst_n, wr, rd, seated, cb, irq_n, ad11, ad13, ad15, cbe0_n, gnt_n, card_clk, rst_oe, irq, busy;
  logic io16_n, req_n, rst_o, serr, breq, audio, pme, clkrun;
  logic [3:0] addr, wlen;
  logic [7:0] wdata, rdata, v;
  pcs_cardin_s card_in;
  pcs_strobe_s so;
  pcs_mode_e mode;
  int n_mismatch = 0;
  int samples_checked = 0;
  pcs_socket pcs_socket_inst (.SYS_CLK(clk), .RST_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr),
    .REG_RD(rd), .REG_RDATA(rdata), .CARD_IN(card_in), .CARD_CLK(card_clk), .CB_AD11(ad11), .CB_AD13(ad13),
    .CB_AD15(ad15), .CB_CBE0_N(cbe0_n), .CB_GNT_N(gnt_n), .SOCKET_OUT(so), .CARD_RESET_O(rst_o),
    .CARD_RESET_OE(rst_oe), .SOCKET_MODE(mode), .CARD_IRQ(irq), .CARD_SERR(serr), .CARD_BUS_REQ(breq),
    .CARD_AUDIO(audio), .PME_EVENT(pme), .CLKRUN_ACTIVE(clkrun), .CYCLE_BUSY(busy));
  pcs_card_model pcs_card_model_inst (.clk(clk), .seated(seated), .cb_card(cb), .irq_n(irq_n), .io16_n(io16_n),
    .req_n(req_n), .wait_len(wlen), .strobes(so), .card_in(card_in), .card_clk(card_clk));
  task chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task wreg(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rreg(input logic [3:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask
  // reference pattern of one socket cycle, then its length against wait
  task go(input logic w, io, wd, a0, b8, input logic [3:0] wl);
    pcs_strobe_s e;
    int n;
    logic b;
    // an io card that leaves its size pin high is served byte-wide
    b = b8 || (io && io16_n);
    e = '{io_read_strobe_n_n: !(io && !w), iowr_n: !(io && w), oe_n: !(!io && !w), we_n: !(!io && w),
      ce1_n: !b && !wd && a0, ce2_n: b || !(wd || a0), a0: a0};
    wlen <= wl;
    wreg(PCS_REG_CYCLE, {3'h0, 1'b1, a0, wd, io, w});
    n = 0;
    while (busy !== 1'b1 && n < 5) begin
      tick(1);
      n++;
    end
    chk("strobes", 8'(so), 8'(e));
    n = 0;
    while (busy === 1'b1 && n < 60) begin
      tick(1);
      n++;
    end
    chk("cycle_len", 8'(n >= (wl > 5 ? wl : 5)), 8'h01);
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #200000;
    n_mismatch++;
    wrap_up();
  end
  // --------------------------------
  // main sequence
  // --------------------------------
  initial begin
    {rst_n, wr, rd, seated, cb, io16_n, addr, wlen, wdata} = 22'h0;
    {irq_n, req_n, ad11, ad13, ad15, cbe0_n, gnt_n} = 7'h7F;
    void'($urandom(32'h45f2a277));
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    tick(2);
    rreg(PCS_REG_CTRL);
    chk("ctrl", v, PCS_RESET_BYTE);
    rreg(4'hF);
    chk("unmapped", v, 8'h00);
    chk("mode_none", 8'(mode), 8'(PCS_MODE_NONE));
    seated <= 1'b1;
    tick(8);
    chk("mode_mem", 8'(mode), 8'(PCS_MODE_MEM));
    rreg(PCS_REG_STATUS);
    chk("status_mem", v, 8'h37);
    chk("rst_oe_off", 8'(rst_oe), 8'h00);
    wreg(PCS_REG_CTRL, 8'h03);
    tick(4);
    chk("rst_oe_on", 8'(rst_oe), 8'h01);
    chk("rst_o_mem", 8'(rst_o), 8'h00);
    chk("mem_audio", 8'(audio), 8'h00);
    repeat (8) go(1'($urandom), 1'b0, 1'($urandom), 1'($urandom), 1'b0, 4'($urandom % 8));
    wreg(PCS_REG_CTRL, 8'h07);
    tick(6);
    chk("mode_io", 8'(mode), 8'(PCS_MODE_IO));
    req_n <= 1'b0;
    wreg(PCS_REG_INTGEN, 8'h80);
    rreg(PCS_REG_INTGEN);
    chk("intgen", v, 8'h80);
    rreg(PCS_REG_STATUS);
    chk("status_io", v, 8'h0F);
    chk("io_req_ignored", 8'(breq), 8'h00);
    chk("io_audio", 8'(audio), 8'h00);
    req_n <= 1'b1;
    go(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 4'h7);
    go(1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 4'h0);
    io16_n <= 1'b1;
    tick(4);
    go(1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 4'h2);
    io16_n <= 1'b0;
    irq_n <= 1'b0;
    tick(6);
    chk("io_irq", 8'(irq), 8'h01);
    irq_n <= 1'b1;
    wreg(PCS_REG_CTRL, 8'h0F);
    go(1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 4'h0);
    go(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 4'h3);
    wreg(PCS_REG_CTRL, 8'h00);
    seated <= 1'b0;
    tick(6);
    cb <= 1'b1;
    seated <= 1'b1;
    tick(8);
    chk("mode_cb", 8'(mode), 8'(PCS_MODE_CB));
    wreg(PCS_REG_CTRL, 8'h03);
    wreg(PCS_REG_CYCLE, 8'h10);
    tick(4);
    chk("cb_refused", 8'(busy), 8'h00);
    chk("cb_rst_o", 8'(rst_o), 8'h01);
    chk("cb_audio", 8'(audio), 8'h01);
    chk("cb_pme_off", 8'(pme), 8'h00);
    wreg(PCS_REG_LEGACY, 8'h0C);
    rreg(PCS_REG_LEGACY);
    chk("legacy", v, 8'h0C);
    wreg(PCS_REG_CTRL, 8'h43);
    req_n <= 1'b0;
    tick(6);
    chk("cb_pme", 8'(pme), 8'h01);
    chk("cb_req", 8'(breq), 8'h01);
    chk("clkrun_idle", 8'(clkrun), 8'h00);
    req_n <= 1'b1;
    repeat (4) begin
      {ad11, ad13, ad15, cbe0_n, gnt_n} <= 5'($urandom);
      tick(4);
      v = 8'({ad11, ad13, ad15, cbe0_n, gnt_n});
      chk("cb_pins", 8'({so.oe_n, so.io_read_strobe_n_n, so.iowr_n, so.ce1_n, so.we_n}), v);
    end
    // a fresh enable edge makes the card hold its error line low for a while
    wlen <= 4'h8;
    cbe0_n <= 1'b1;
    tick(12);
    chk("cb_serr_off", 8'(serr), 8'h00);
    cbe0_n <= 1'b0;
    tick(5);
    chk("cb_serr", 8'(serr), 8'h01);
    irq_n <= 1'b0;
    tick(6);
    chk("cb_irq", 8'(irq), 8'h01);
    wrap_up();
  end
endmodule
